// ==== rtl/pcc_peak_current_chopper.sv ====
// Peak current chopping controller for a full-bridge driver.
//
// Overview of operation
// - During discharge both bridge outputs are driven low (short brake).
// - Charge ends and discharge starts once sensed current reaches the reference.
// - Discharge lasts 39 internal ticks of 4 oscillator cycles plus a delay.
// - If sensed current is still high at expiry, start another full discharge.
// - If sensed current is low at expiry, charge until it reaches the reference.
// - A reference change mid-discharge never shortens the discharge interval.
// - The oscillator period, set by the timing resistor, scales the interval.
// - Dead time with all transistors off is inserted on each drive/brake change.
`timescale 1ns/1ps
`include "pcc_params.svh"

module pcc_peak_current_chopper
    import pcc_pkg::*;
#(
    parameter int DISCHARGE_TICKS = `PCC_DISCHARGE_TICKS,
    parameter int OSC_PER_TICK = `PCC_OSC_PER_TICK,
    parameter int DELAY_CYC = `PCC_ANALOG_DELAY_CYC,
    parameter int DEAD_CYC = `PCC_DEAD_TIME_CYC
) (
    // Clock from the timing oscillator and reset.
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // Drive request and polarity.
    input wire logic drive_en_in,
    input wire logic drive_dir_in,
    // Comparator: sensed_current_voltage at or above the reference.
    input wire logic sense_at_limit_in,
    // Bridge gate controls, high side and low side of each half-bridge.
    output logic bridge_output_a_hi_out,
    output logic bridge_output_a_lo_out,
    output logic bridge_output_b_hi_out,
    output logic bridge_output_b_lo_out,
    // Phase status.
    output logic discharge_out
);

    localparam int CW = `PCC_CNT_W;

    // Counters are CW bits wide, so spans beyond them or of zero length are refused.
    if (DISCHARGE_TICKS < 1 || DISCHARGE_TICKS > 255 || OSC_PER_TICK < 1 ||
        OSC_PER_TICK > 255 || DELAY_CYC < 1 || DELAY_CYC > 255 ||
        DEAD_CYC < 1 || DEAD_CYC > 255) begin : g_param_check
        $error("pcc_peak_current_chopper: parameter out of range");
    end

    // Reset release through two flip-flops.
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Comparator synchroniser; only the second stage is used by logic.
    logic sense_meta_q;
    logic sense_q;
    always_ff @(posedge core_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sense_meta_q <= 1'b0;
            sense_q <= 1'b0;
        end else begin
            sense_meta_q <= sense_at_limit_in;
            sense_q <= sense_meta_q;
        end
    end

    // Divide the oscillator clock into internal ticks. The oscillator
    // itself, trimmed by timing_resistor_pin, is what drives core_clk_in,
    // so the discharge time scales with that resistor.
    logic [CW-1:0] div_q;
    logic [CW-1:0] div_d;
    logic tick;
    logic div_clr;
    assign tick = (div_q == CW'(OSC_PER_TICK - 1));
    assign div_d = (div_clr || tick) ? '0 : div_q + 8'h01;

    // Main phase machine.
    pcc_state_t state_q;
    pcc_state_t state_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic cnt_done;
    logic tick_done;
    logic want_drive;

    assign cnt_done = (cnt_q == 8'h00);
    assign tick_done = tick && (cnt_q == 8'h01);
    assign want_drive = drive_en_in;
    // Restart the divider as each discharge begins so all 39 ticks are whole.
    assign div_clr = (state_q != PCC_DISCHARGE);

    // Dead-time and delay counts load one less than the span, since the load cycle is the first.
    function automatic logic [CW-1:0] span_load(input int span);
        return CW'(span - 1);
    endfunction : span_load

    // Shared decrement for every down-counting phase.
    function automatic logic [CW-1:0] count_down(input logic [CW-1:0] value);
        return value - 8'h01;
    endfunction : count_down

    // Direction is held while charging; a new one is taken only after dead time.
    logic dir_q;
    logic dir_d;
    logic dir_flip;
    assign dir_d = (state_q == PCC_CHARGE) ? dir_q : drive_dir_in;
    assign dir_flip = (drive_dir_in != dir_q);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            PCC_IDLE: begin
                if (want_drive) begin
                    state_d = PCC_DEAD_TO_DRIVE;
                    cnt_d = span_load(DEAD_CYC);
                end
            end
            PCC_CHARGE: begin
                if (!want_drive || sense_q) begin
                    state_d = PCC_DEAD_TO_BRAKE;
                    cnt_d = span_load(DEAD_CYC);
                end else if (dir_flip) begin
                    // Reversing would swap both legs at once, so all gates rest first.
                    state_d = PCC_DEAD_TO_DRIVE;
                    cnt_d = span_load(DEAD_CYC);
                end
            end
            PCC_DEAD_TO_BRAKE: begin
                if (cnt_done) begin
                    state_d = want_drive ? PCC_DISCHARGE : PCC_IDLE;
                    cnt_d = CW'(DISCHARGE_TICKS);
                end else begin
                    cnt_d = count_down(cnt_q);
                end
            end
            PCC_DISCHARGE: begin
                // Only the tick count or a dropped drive request ends this phase; the comparator is ignored.
                if (!want_drive) begin
                    state_d = PCC_IDLE;
                end else if (tick_done) begin
                    state_d = PCC_DELAY;
                    cnt_d = span_load(DELAY_CYC);
                end else if (tick) begin
                    cnt_d = count_down(cnt_q);
                end
            end
            PCC_DELAY: begin
                if (!want_drive) begin
                    state_d = PCC_IDLE;
                end else if (cnt_done) begin
                    if (sense_q) begin
                        state_d = PCC_DISCHARGE;
                        cnt_d = CW'(DISCHARGE_TICKS);
                    end else begin
                        state_d = PCC_DEAD_TO_DRIVE;
                        cnt_d = span_load(DEAD_CYC);
                    end
                end else begin
                    cnt_d = count_down(cnt_q);
                end
            end
            PCC_DEAD_TO_DRIVE: begin
                if (!want_drive) begin
                    state_d = PCC_IDLE;
                end else if (cnt_done) begin
                    state_d = PCC_CHARGE;
                end else begin
                    cnt_d = count_down(cnt_q);
                end
            end
            default: begin
                state_d = PCC_IDLE;
                cnt_d = '0;
            end
        endcase
    end

    // Output decode: all gates off in dead time and idle, low sides on to brake.
    logic drv_phase;
    logic brk_phase;
    logic a_hi_d;
    logic a_lo_d;
    logic b_hi_d;
    logic b_lo_d;
    assign drv_phase = (state_d == PCC_CHARGE);
    assign brk_phase = (state_d == PCC_DISCHARGE) || (state_d == PCC_DELAY);
    assign a_hi_d = drv_phase && !dir_d;
    assign b_hi_d = drv_phase && dir_d;
    assign a_lo_d = brk_phase || (drv_phase && dir_d);
    assign b_lo_d = brk_phase || (drv_phase && !dir_d);

    // State and registered outputs.
    always_ff @(posedge core_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= PCC_IDLE;
            cnt_q <= '0;
            div_q <= '0;
            bridge_output_a_hi_out <= 1'b0;
            bridge_output_a_lo_out <= 1'b0;
            bridge_output_b_hi_out <= 1'b0;
            bridge_output_b_lo_out <= 1'b0;
            discharge_out <= 1'b0;
            dir_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            div_q <= div_d;
            bridge_output_a_hi_out <= a_hi_d;
            bridge_output_a_lo_out <= a_lo_d;
            bridge_output_b_hi_out <= b_hi_d;
            bridge_output_b_lo_out <= b_lo_d;
            discharge_out <= brk_phase;
            dir_q <= dir_d;
        end
    end

endmodule : pcc_peak_current_chopper

// ==== rtl/pcc_params.svh ====
// Constants for the peak current chopper.
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH
`define PCC_DISCHARGE_TICKS 39
`define PCC_OSC_PER_TICK 4
`define PCC_ANALOG_DELAY_NS 100
`define PCC_CLK_PERIOD_NS 100
`define PCC_ANALOG_DELAY_CYC ((`PCC_ANALOG_DELAY_NS + `PCC_CLK_PERIOD_NS - 1) / `PCC_CLK_PERIOD_NS)
`define PCC_DEAD_TIME_NS 200
`define PCC_DEAD_TIME_CYC ((`PCC_DEAD_TIME_NS + `PCC_CLK_PERIOD_NS - 1) / `PCC_CLK_PERIOD_NS)
`define PCC_CNT_W 8
`endif

// ==== rtl/pcc_pkg.sv ====
// Types for the peak current chopper.
package pcc_pkg;
    typedef enum logic [2:0] {
        PCC_IDLE,
        PCC_CHARGE,
        PCC_DEAD_TO_BRAKE,
        PCC_DISCHARGE,
        PCC_DELAY,
        PCC_DEAD_TO_DRIVE
    } pcc_state_t;
endpackage : pcc_pkg

// ==== verif/pcc_coil_model.sv ====
// Coil and sense resistor model that turns gate states into a comparator level.
`timescale 1ns/1ps
module pcc_coil_model (
    // Model clock.
    input wire logic clk_in,
    // Gate states seen from the bridge.
    input wire logic a_hi_in,
    input wire logic a_lo_in,
    input wire logic b_hi_in,
    input wire logic b_lo_in,
    // Current limit and comparator result.
    input wire logic [7:0] limit_in,
    output logic at_limit_out
);
    logic [7:0] cur_q = 8'h00;
    logic [3:0] dec_q = 4'h0;
    // Driving ramps fast and braking decays slowly, so a lowered limit stays exceeded.
    always @(posedge clk_in) begin
        dec_q <= dec_q + 4'h1;
        if ((a_hi_in && b_lo_in) || (b_hi_in && a_lo_in)) cur_q <= cur_q + 8'h01;
        else if (cur_q != 8'h00 && dec_q == 4'h0) cur_q <= cur_q - 8'h01;
    end
    assign at_limit_out = (cur_q >= limit_in);
endmodule : pcc_coil_model

// ==== verif/pcc_checker.sv ====
// Port assertions for the peak current chopper.
`timescale 1ns/1ps
`include "pcc_params.svh"
module pcc_checker #(
    parameter int DISCHARGE_TICKS = `PCC_DISCHARGE_TICKS,
    parameter int OSC_PER_TICK = `PCC_OSC_PER_TICK,
    parameter int DELAY_CYC = `PCC_ANALOG_DELAY_CYC
) (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // Drive request, polarity and comparator.
    input wire logic drive_en_in,
    input wire logic drive_dir_in,
    input wire logic sense_at_limit_in,
    // Gate controls and phase status.
    input wire logic bridge_output_a_hi_out,
    input wire logic bridge_output_a_lo_out,
    input wire logic bridge_output_b_hi_out,
    input wire logic bridge_output_b_lo_out,
    input wire logic discharge_out
);
    localparam int DLEN = DISCHARGE_TICKS * OSC_PER_TICK + DELAY_CYC;
    wire hi = bridge_output_a_hi_out || bridge_output_b_hi_out;
    wire lo = bridge_output_a_lo_out || bridge_output_b_lo_out;
    logic [11:0] dcnt_q;
    // Length of the running brake, so that its end can be judged.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) dcnt_q <= 12'h000;
        else dcnt_q <= discharge_out ? dcnt_q + 12'h001 : 12'h000;
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    sequence s_calm; (!sense_at_limit_in && drive_en_in && $stable(drive_dir_in)) [*4]; endsequence
    sequence s_dead; !(hi || lo) [*2]; endsequence
    chk_brake_low: assert property (discharge_out |-> !hi &&
        bridge_output_a_lo_out && bridge_output_b_lo_out) else $error("brake gates wrong");
    chk_limit_stop: assert property ($rose(sense_at_limit_in) && hi |-> ##[1:4] !hi)
        else $error("charge not ended");
    chk_brake_start: assert property ($fell(hi) && drive_en_in &&
        drive_dir_in == $past(drive_dir_in, 2) |-> ##2 discharge_out)
        else $error("brake late");
    chk_brake_len: assert property ($fell(discharge_out) |-> dcnt_q % DLEN == 0)
        else $error("brake length");
    chk_charge_back: assert property ($fell(discharge_out) && drive_en_in |-> s_dead ##1 hi)
        else $error("no charge");
    chk_charge_hold: assert property (s_calm ##0 hi |=> hi) else $error("charge dropped");
    chk_dead_brake: assert property ($fell(hi) |-> !lo [*2]) else $error("dead time");
    chk_dead_drive: assert property ($fell(lo) |-> !hi [*2]) else $error("dead time");
    chk_no_shoot: assert property (!(bridge_output_a_hi_out && bridge_output_a_lo_out) &&
        !(bridge_output_b_hi_out && bridge_output_b_lo_out)) else $error("shoot through");
    chk_leg_a_gap: assert property (bridge_output_a_hi_out |=> !bridge_output_a_lo_out [*2])
        else $error("leg a dead time");
    chk_leg_b_gap: assert property (bridge_output_b_hi_out |=> !bridge_output_b_lo_out [*2])
        else $error("leg b dead time");
endmodule : pcc_checker

// ==== verif/peak_current_chopper_tb_top.sv ====
// Self-checking bench for the peak current chopper against a coil model.
`timescale 1ns/1ps
`include "pcc_params.svh"
module peak_current_chopper_tb_top;
    localparam int DLEN = `PCC_DISCHARGE_TICKS * `PCC_OSC_PER_TICK + `PCC_ANALOG_DELAY_CYC;
    logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, dir = 1'b0, a_hi, a_lo, b_hi, b_lo, dis, sense;
    logic [7:0] lim = 8'h14;
    int n_errors = 0, compares = 0, cyc = 0;
    time t0;
    pcc_peak_current_chopper DUT (.core_clk_in(clk), .arst_n_in(rst_n), .drive_en_in(en),
        .drive_dir_in(dir), .sense_at_limit_in(sense), .bridge_output_a_hi_out(a_hi),
        .bridge_output_a_lo_out(a_lo), .bridge_output_b_hi_out(b_hi),
        .bridge_output_b_lo_out(b_lo), .discharge_out(dis));
    pcc_coil_model u_coil (.clk_in(clk), .a_hi_in(a_hi), .a_lo_in(a_lo), .b_hi_in(b_hi),
        .b_lo_in(b_lo), .limit_in(lim), .at_limit_out(sense));
    initial forever #50 clk = ~clk;
    // A hung wait ends here instead of running on.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // Times one unbroken brake of reps back-to-back discharge intervals, moving the limit part way through it.
    task automatic brake_run(input logic [7:0] new_lim, input int reps);
        wait (dis === 1'b1);
        #1 t0 = $time;
        check({a_hi, b_hi, a_lo, b_lo}, 4'h3);
        repeat (20) @(posedge clk);
        lim <= new_lim;
        wait (dis === 1'b0);
        #1 check(32'($time - t0), 32'(reps * DLEN * 100));
        repeat (3) @(posedge clk);
        #1 check(dir ? b_hi : a_hi, 1'b1);
    endtask : brake_run
    task automatic s_chop(input logic d);
        @(posedge clk);
        dir <= d;
        // A reversal mid-charge must pass through a cycle with every gate off.
        @(posedge clk);
        #1 check({a_hi, b_hi, a_lo, b_lo}, 4'h0);
        brake_run(8'h14, 1);
    endtask : s_chop
    // Dropping the drive request turns every gate off and keeps it off.
    task automatic s_stop();
        @(posedge clk);
        en <= 1'b0;
        repeat (4) @(posedge clk);
        #1 check({a_hi, a_lo, b_hi, b_lo, dis}, 5'h00);
    endtask : s_stop
    task automatic s_ref_down();
        brake_run(8'h08, 2);
    endtask : s_ref_down
    // The charge must last until the raised limit is met.
    task automatic s_ref_up();
        brake_run(8'h28, 1);
        repeat (10) @(posedge clk);
        #1 check(dis, 1'b0);
    endtask : s_ref_up
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1 check({a_hi, a_lo, b_hi, b_lo, dis}, 5'h00);
        @(posedge clk);
        en <= 1'b1;
        s_chop(1'b0);
        s_chop(1'b1);
        s_ref_down();
        s_ref_up();
        s_stop();
        report_and_stop();
    end
endmodule : peak_current_chopper_tb_top
bind pcc_peak_current_chopper pcc_checker #(.DISCHARGE_TICKS(DISCHARGE_TICKS),
    .OSC_PER_TICK(OSC_PER_TICK), .DELAY_CYC(DELAY_CYC)) u_chk (.core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in), .drive_en_in(drive_en_in), .drive_dir_in(drive_dir_in),
    .sense_at_limit_in(sense_at_limit_in), .bridge_output_a_hi_out(bridge_output_a_hi_out),
    .bridge_output_a_lo_out(bridge_output_a_lo_out),
    .bridge_output_b_hi_out(bridge_output_b_hi_out),
    .bridge_output_b_lo_out(bridge_output_b_lo_out), .discharge_out(discharge_out));
